// >>> design/fmrp_pkg.sv
// Purpose: shared constants and carriers of the flash mode, reset and power control block
// Assumes: core clock at 200 MHz; serial opcodes arrive msb first
// Notes: timing counts derive from printed times and the clock period
package fmrp_pkg;

  // opcodes handled by this block
  localparam logic [7:0] OP_EXIT_QUAD = 8'hff;
  localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_UDPD = 8'h79;

  // reset values of the volatile settings
  localparam logic [7:0] READ_PARAM_RST = 8'h00; // 2 dummy clocks, 8-byte wrap
  localparam logic [2:0] WRAP_BITS_RST = 3'h0; // 8-byte wrap length
  localparam int BITS_PER_BYTE = 8;

  // time base
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RESET_TIME_NS = 30000;
  localparam int UDPD_ENTRY_TIME_NS = 3000; // longest entry time
  localparam int UDPD_EXIT_TIME_NS = 3000; // longest exit time
  localparam int SELECT_LOW_WAKE_TIME_NS = 100; // least wake pulse
  localparam int POWERUP_SELECT_DELAY_NS = 1000000; // host side wait

  // least times round up, longest times round down, never below one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_down(input int ns);
    int c;
    c = (ns * 1000) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RESET_CYC = cyc_up(RESET_TIME_NS);
  localparam int UDPD_ENTRY_CYC = cyc_down(UDPD_ENTRY_TIME_NS);
  localparam int UDPD_EXIT_CYC = cyc_down(UDPD_EXIT_TIME_NS);
  localparam int WAKE_CYC = cyc_up(SELECT_LOW_WAKE_TIME_NS);

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_RST_WAIT = 3'b001,
    ST_UDPD_ENTER = 3'b010,
    ST_UDPD = 3'b011,
    ST_UDPD_EXIT = 3'b100
  } fmrp_state_e;

  // volatile settings held by this block
  typedef struct packed {
    logic quad_command_mode;
    logic write_enable_latch;
    logic suspend_flag;
    logic [7:0] read_param_bits;
    logic [2:0] wrap_bits;
  } fmrp_vol_s;

  // update requests from the rest of the command logic
  typedef struct packed {
    logic latch_set;
    logic latch_clr;
    logic susp_set;
    logic susp_clr;
    logic param_we;
    logic [7:0] param;
    logic wrap_we;
    logic [2:0] wrap;
  } fmrp_upd_s;

endpackage

// >>> design/fmrp_ctrl.sv
// Purpose: opcode capture, quad mode exit, two-step reset and ultra-deep power-down
// Assumes: select, serial clock and data lanes come from outside the core clock domain
// Notes: commands act on the rise of select; outputs all come from flip-flops
`timescale 1ns/1ps

module fmrp_ctrl #(
  parameter int RST_CYC = fmrp_pkg::RESET_CYC,
  parameter int ENTRY_CYC = fmrp_pkg::UDPD_ENTRY_CYC,
  parameter int EXIT_CYC = fmrp_pkg::UDPD_EXIT_CYC,
  parameter int WAKE_LOW_CYC = fmrp_pkg::WAKE_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic spi_cs_n,
  input wire logic spi_clk,
  input wire logic [3:0] spi_io,
  input wire logic op_busy,
  input wire logic quad_enable_bit,
  input wire fmrp_pkg::fmrp_upd_s upd,
  output fmrp_pkg::fmrp_vol_s vol,
  output logic op_abort,
  output logic cmd_strobe,
  output logic [7:0] cmd_opcode,
  output logic reset_busy,
  output logic udpd_active,
  output logic standby
);
  import fmrp_pkg::*;

  // counts wider than 16 bits would not fit the shared timer
  if (RST_CYC < 1 || RST_CYC > 65535 || ENTRY_CYC < 1 || ENTRY_CYC > 65535 ||
      EXIT_CYC < 1 || EXIT_CYC > 65535 || WAKE_LOW_CYC < 1 || WAKE_LOW_CYC > 65535)
  begin : g_bad_count
    $error("fmrp_ctrl: timing count out of range");
  end

  localparam logic [15:0] RST_N = 16'(RST_CYC);
  localparam logic [15:0] ENTRY_N = 16'(ENTRY_CYC);
  localparam logic [15:0] EXIT_N = 16'(EXIT_CYC);
  localparam logic [15:0] WAKE_N = 16'(WAKE_LOW_CYC);

  // three-stage synchronisers; a change counts once stages two and three agree
  logic [2:0] cs_sync;
  logic [2:0] clk_sync;
  logic [3:0] io_s1;
  logic [3:0] io_s2;
  logic [3:0] io_s3;
  logic cs_f;
  logic clk_f;
  logic [3:0] io_f;
  logic cs_q;
  logic clk_q;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cs_sync <= 3'h7;
      clk_sync <= 3'h0;
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
      io_s3 <= 4'h0;
    end
    else
    begin
      cs_sync <= {cs_sync[1:0], spi_cs_n};
      clk_sync <= {clk_sync[1:0], spi_clk};
      io_s1 <= spi_io;
      io_s2 <= io_s1;
      io_s3 <= io_s2;
    end
  end

  // filtered levels and their previous values for edge finding
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cs_f <= 1'b1;
      clk_f <= 1'b0;
      io_f <= 4'h0;
      cs_q <= 1'b1;
      clk_q <= 1'b0;
    end
    else
    begin
      cs_f <= (cs_sync[1] == cs_sync[2]) ? cs_sync[2] : cs_f;
      clk_f <= (clk_sync[1] == clk_sync[2]) ? clk_sync[2] : clk_f;
      io_f <= (io_s2 == io_s3) ? io_s3 : io_f;
      cs_q <= cs_f;
      clk_q <= clk_f;
    end
  end

  wire cs_fall = cs_q & ~cs_f;
  wire cs_rise = ~cs_q & cs_f;
  wire sclk_rise = ~clk_q & clk_f & ~cs_f;

  // frame shifter: one lane in spi mode, four lanes in quad command mode
  fmrp_state_e state;
  fmrp_state_e next_state;
  logic [7:0] shreg;
  logic [2:0] bit_cnt;
  logic have_op;
  logic [7:0] opcode;
  logic frame_void;
  logic armed;
  logic [15:0] timer;
  logic [15:0] low_cnt;

  wire [3:0] step = vol.quad_command_mode ? 4'h4 : 4'h1;
  wire [3:0] bit_sum = {1'b0, bit_cnt} + step;
  wire [7:0] next_shreg = vol.quad_command_mode ? {shreg[3:0], io_f} : {shreg[6:0], io_f[0]};
  wire byte_done = sclk_rise & bit_sum[3];

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shreg <= 8'h00;
      bit_cnt <= 3'h0;
      have_op <= 1'b0;
      opcode <= 8'h00;
    end
    else if (cs_fall)
    begin
      bit_cnt <= 3'h0;
      have_op <= 1'b0;
    end
    else if (sclk_rise)
    begin
      shreg <= next_shreg;
      bit_cnt <= bit_sum[2:0];
      have_op <= have_op | byte_done;
      opcode <= (byte_done && !have_op) ? next_shreg : opcode; // later bytes dropped
    end
  end

  // a frame that began outside standby is void for its whole length
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      frame_void <= 1'b0;
    else if (cs_fall)
      frame_void <= (state != ST_STANDBY);
  end

  // a frame counts only if the opcode is whole and select rose on a byte boundary
  wire frame_ok = cs_rise & have_op & (bit_cnt == 3'h0) & ~frame_void;
  wire live = frame_ok & (state == ST_STANDBY);
  wire do_reset = live & armed & (opcode == OP_RESET);
  wire do_udpd = live & (opcode == OP_UDPD) & ~op_busy;
  wire do_exit_q = live & (opcode == OP_EXIT_QUAD) & vol.quad_command_mode;
  wire do_enter_q = live & (opcode == OP_ENTER_QUAD) & ~vol.quad_command_mode & quad_enable_bit;
  wire upd_ok = (state == ST_STANDBY) & ~do_reset;
  wire wake_ok = cs_rise & (state == ST_UDPD) & (low_cnt >= WAKE_N);
  wire timer_done = (timer == 16'h0001);

  // state sequencing; the timer counts down the stay in each timed state
  always_comb
  begin
    next_state = state;
    case (state)
      ST_STANDBY:
      begin
        if (do_reset)
          next_state = ST_RST_WAIT;
        else if (do_udpd)
          next_state = ST_UDPD_ENTER;
      end
      ST_RST_WAIT:
        next_state = timer_done ? ST_STANDBY : ST_RST_WAIT;
      ST_UDPD_ENTER:
        next_state = timer_done ? ST_UDPD : ST_UDPD_ENTER;
      ST_UDPD:
        next_state = wake_ok ? ST_UDPD_EXIT : ST_UDPD;
      ST_UDPD_EXIT:
        next_state = timer_done ? ST_STANDBY : ST_UDPD_EXIT;
      default:
        next_state = ST_STANDBY;
    endcase
  end

  // power cycle starts in standby, never in power-down
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      state <= ST_STANDBY;
    else
      state <= next_state;
  end

  // timer loads on entry to a timed state and counts down to zero; the state ends when it reads one
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      timer <= 16'h0000;
    else if (do_reset)
      timer <= RST_N;
    else if (do_udpd)
      timer <= ENTRY_N;
    else if (wake_ok)
      timer <= EXIT_N;
    else if (timer != 16'h0000)
      timer <= timer - 16'h0001;
  end

  // select low time during power-down, saturating so long pulses still wake
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      low_cnt <= 16'h0000;
    else if (cs_f || state != ST_UDPD)
      low_cnt <= 16'h0000;
    else if (low_cnt != 16'hffff)
      low_cnt <= low_cnt + 16'h0001;
  end

  // armed state: set by 66h, dropped by any other whole command in standby
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      armed <= 1'b0;
    else if (live)
      armed <= (opcode == OP_RESET_ARM);
  end

  // volatile settings; reset wins over every update since it aborts everything
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      vol.quad_command_mode <= 1'b0;
      vol.write_enable_latch <= 1'b0;
      vol.suspend_flag <= 1'b0;
      vol.read_param_bits <= READ_PARAM_RST;
      vol.wrap_bits <= WRAP_BITS_RST;
    end
    else if (do_reset)
    begin
      vol.quad_command_mode <= 1'b0;
      vol.write_enable_latch <= 1'b0;
      vol.suspend_flag <= 1'b0;
      vol.read_param_bits <= READ_PARAM_RST;
      vol.wrap_bits <= WRAP_BITS_RST;
    end
    else
    begin
      // leaving quad mode touches only the mode bit
      if (do_exit_q)
        vol.quad_command_mode <= 1'b0;
      else if (do_enter_q)
        vol.quad_command_mode <= 1'b1;
      // set wins over clear so a late set is never lost
      if (upd_ok && upd.latch_set)
        vol.write_enable_latch <= 1'b1;
      else if (upd_ok && upd.latch_clr)
        vol.write_enable_latch <= 1'b0;
      if (upd_ok && upd.susp_set)
        vol.suspend_flag <= 1'b1;
      else if (upd_ok && upd.susp_clr)
        vol.suspend_flag <= 1'b0;
      if (upd_ok && upd.param_we)
        vol.read_param_bits <= upd.param;
      // entering quad mode puts wrap back to its default
      if (do_enter_q)
        vol.wrap_bits <= WRAP_BITS_RST;
      else if (upd_ok && upd.wrap_we)
        vol.wrap_bits <= upd.wrap;
    end
  end

  // status outputs and strobes, all registered
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      op_abort <= 1'b0;
      cmd_strobe <= 1'b0;
      cmd_opcode <= 8'h00;
      reset_busy <= 1'b0;
      udpd_active <= 1'b0;
      standby <= 1'b1;
    end
    else
    begin
      op_abort <= do_reset;
      cmd_strobe <= live;
      cmd_opcode <= live ? opcode : cmd_opcode;
      reset_busy <= (next_state == ST_RST_WAIT);
      udpd_active <= (next_state == ST_UDPD);
      standby <= (next_state == ST_STANDBY);
    end
  end

endmodule

// >>> sim/fmrp_ctrl_assertions.sv
// Purpose: concurrent checks on the mode, reset and power-down control ports
// Assumes: one core clock domain, asynchronous active high reset
// Notes: entry and exit bounds allow two cycles of slack for the output flops
`timescale 1ns/1ps
module fmrp_ctrl_assertions #(
  parameter int RST_CYC = 6000,
  parameter int ENTRY_CYC = 600,
  parameter int EXIT_CYC = 600,
  parameter int WAKE_LOW_CYC = 20
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic spi_cs_n,
  input wire logic spi_clk,
  input wire logic [3:0] spi_io,
  input wire logic op_busy,
  input wire logic quad_enable_bit,
  input wire fmrp_pkg::fmrp_upd_s upd,
  input wire fmrp_pkg::fmrp_vol_s vol,
  input wire logic op_abort,
  input wire logic cmd_strobe,
  input wire logic [7:0] cmd_opcode,
  input wire logic reset_busy,
  input wire logic udpd_active,
  input wire logic standby
);
  import fmrp_pkg::*;
  localparam int ENTRY_LIM = ENTRY_CYC + 2;
  localparam int EXIT_LIM = EXIT_CYC + 2;
  int busy_cnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // length of the running recovery span; a counter keeps long spans cheap to check
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      busy_cnt <= 0;
    else
      busy_cnt <= reset_busy ? busy_cnt + 1 : 0;
  end
  // the two accepted commands that start multi-step behaviour
  sequence s_reset_taken;
    op_abort && cmd_strobe && cmd_opcode == OP_RESET;
  endsequence
  sequence s_udpd_taken;
    cmd_strobe && cmd_opcode == OP_UDPD && !standby;
  endsequence
  a_abort_is_reset: assert property (op_abort |-> s_reset_taken)
    else $error("abort without reset opcode");
  a_reset_clears: assert property (s_reset_taken |-> vol == '0 && reset_busy && !standby
    ##1 !op_abort) else $error("reset left settings or state");
  a_recovery_span: assert property ($fell(reset_busy) |->
    busy_cnt inside {[RST_CYC - 1:RST_CYC + 1]}) else $error("recovery length");
  a_silent_recovery: assert property (reset_busy && !op_abort |-> !cmd_strobe)
    else $error("command taken in recovery");
  a_silent_udpd: assert property (udpd_active |-> !cmd_strobe && !op_abort)
    else $error("command taken in power-down");
  a_udpd_entry: assert property (s_udpd_taken |-> !udpd_active ##[1:ENTRY_LIM] udpd_active)
    else $error("power-down entry late");
  a_udpd_exit: assert property ($fell(udpd_active) |-> !standby ##[1:EXIT_LIM] standby)
    else $error("power-down exit late");
  a_quad_exit: assert property (cmd_strobe && cmd_opcode == OP_EXIT_QUAD |->
    ##[0:1] !vol.quad_command_mode) else $error("quad mode kept");
  a_states_apart: assert property (standby |-> !udpd_active && !reset_busy)
    else $error("standby overlaps another state");
endmodule

bind fmrp_ctrl fmrp_ctrl_assertions #(.RST_CYC(RST_CYC), .ENTRY_CYC(ENTRY_CYC),
  .EXIT_CYC(EXIT_CYC), .WAKE_LOW_CYC(WAKE_LOW_CYC)) fmrp_ctrl_assertions_i (
  .core_clk(core_clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_clk(spi_clk),
  .spi_io(spi_io), .op_busy(op_busy), .quad_enable_bit(quad_enable_bit), .upd(upd),
  .vol(vol), .op_abort(op_abort), .cmd_strobe(cmd_strobe), .cmd_opcode(cmd_opcode),
  .reset_busy(reset_busy), .udpd_active(udpd_active), .standby(standby));

// >>> sim/fmrp_host_model.sv
// Purpose: host controller model framing opcodes on select, serial clock and lanes
// Assumes: 125 ns serial clock built from 12 plus 13 core cycles
// Notes: serial clock stands low between frames; callers choose the gaps
`timescale 1ns/1ps
module fmrp_host_model (
  input wire logic core_clk,
  output logic spi_cs_n,
  output logic spi_clk,
  output logic [3:0] spi_io
);
  // idle bus at time zero
  initial
  begin
    spi_cs_n = 1'b1;
    spi_clk = 1'b0;
    spi_io = 4'h5;
  end
  // one frame of n bits, msb first, one lane or nibbles on four
  task automatic frame(input logic [15:0] d, input int n, input logic q);
    int i;
    spi_cs_n <= 1'b0;
    repeat (13) @(posedge core_clk);
    for (i = 0; i < n; i += (q ? 4 : 1))
    begin
      spi_io <= q ? 4'(d >> (12 - i)) : {3'h0, d[15 - i]};
      repeat (12) @(posedge core_clk);
      spi_clk <= 1'b1;
      repeat (13) @(posedge core_clk);
      spi_clk <= 1'b0;
    end
    repeat (12) @(posedge core_clk);
    spi_cs_n <= 1'b1;
    // released lanes flip so a stale level never passes for data
    spi_io <= ~spi_io;
    repeat (2) @(posedge core_clk);
  endtask
endmodule

// >>> sim/flash_mode_reset_power_control_bench.sv
// Purpose: self-checking bench of the mode, reset and power-down control block
// Assumes: recovery 50, entry 20, exit 20 and wake 8 core cycles
// Notes: pulses are counted by a watcher so frames need no cycle-exact sampling
`timescale 1ns/1ps
module flash_mode_reset_power_control_bench;
  import fmrp_pkg::*;
  localparam int ENT_N = 20;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic op_busy = 1'b0;
  logic quad_enable_bit = 1'b0;
  fmrp_upd_s upd = '0;
  fmrp_vol_s vol;
  logic spi_cs_n, spi_clk, op_abort, cmd_strobe, reset_busy, udpd_active, standby;
  logic [3:0] spi_io;
  logic [7:0] cmd_opcode;
  int errors = 0, samples_checked = 0, strobes = 0, aborts = 0, s, a;
  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;
  fmrp_ctrl #(.RST_CYC(50), .ENTRY_CYC(ENT_N), .EXIT_CYC(20), .WAKE_LOW_CYC(8)) fmrp_ctrl_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_clk(spi_clk),
    .spi_io(spi_io), .op_busy(op_busy), .quad_enable_bit(quad_enable_bit),
    .upd(upd), .vol(vol),
    .op_abort(op_abort), .cmd_strobe(cmd_strobe), .cmd_opcode(cmd_opcode),
    .reset_busy(reset_busy), .udpd_active(udpd_active), .standby(standby));
  fmrp_host_model fmrp_host_model_i (.core_clk(core_clk), .spi_cs_n(spi_cs_n),
    .spi_clk(spi_clk), .spi_io(spi_io));
  // pulse watcher
  always @(posedge core_clk)
  begin
    if (cmd_strobe === 1'b1) strobes++;
    if (op_abort === 1'b1) aborts++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // frame plus a settling gap long enough for the strobe to land
  task automatic fm(input logic [15:0] d, input int n, input logic q);
    fmrp_host_model_i.frame(d, n, q);
    repeat (10) @(posedge core_clk);
  endtask
  task automatic t_power_on;
    check(16'(vol), 16'h0000);
    check({13'h0, standby, udpd_active, reset_busy}, 16'h0004);
  endtask
  task automatic t_quad;
    fm(16'h3800, 8, 1'b0); // quad entry refused while the enable bit is low
    check(16'(vol.quad_command_mode), 16'h0000);
    quad_enable_bit <= 1'b1;
    fm(16'h3800, 8, 1'b0);
    check(16'(vol.quad_command_mode), 16'h0001);
    upd <= '{latch_set: 1'b1, susp_set: 1'b1, param_we: 1'b1, param: 8'h3c, wrap_we: 1'b1,
      wrap: 3'h5, default: '0};
    @(posedge core_clk);
    upd <= '0;
    fm(16'hff00, 8, 1'b1);
    check(16'(vol.quad_command_mode), 16'h0000);
    check({11'h0, vol.write_enable_latch, vol.suspend_flag, vol.wrap_bits}, 16'h001d);
  endtask
  task automatic t_reset;
    fm(16'h3800, 8, 1'b0);
    a = aborts;
    fm(16'h6600, 8, 1'b1);
    fm(16'h0500, 8, 1'b1);
    fm(16'h9900, 8, 1'b1);
    check(16'(aborts), 16'(a));
    fm(16'h6600, 8, 1'b1); // op_busy is low, no erase is cut short
    fmrp_host_model_i.frame(16'h9900, 8, 1'b1);
    repeat (8) @(posedge core_clk);
    check(16'(aborts), 16'(a + 1));
    check({vol, reset_busy, standby}, 16'h0002);
    check(16'(cmd_opcode), 16'h0099);
    // updates offered during recovery must leave the cleared settings alone
    upd <= '{latch_set: 1'b1, susp_set: 1'b1, default: '0};
    @(posedge core_clk);
    upd <= '0;
    s = strobes;
    fm(16'h6600, 8, 1'b0); // select falls inside recovery, so this frame is void
    check(16'(strobes), 16'(s));
    check({vol, reset_busy, standby}, 16'h0001);
    fm(16'h9900, 8, 1'b0);
    check(16'(aborts), 16'(a + 1));
  endtask
  task automatic t_udpd;
    int n;
    s = strobes;
    for (n = 4; n <= 12; n += 8)
      fm(16'h7900, n, 1'b0);
    check(16'(strobes), 16'(s));
    check({14'h0, udpd_active, standby}, 16'h0001);
    op_busy <= 1'b1;
    fm(16'h7900, 8, 1'b0);
    op_busy <= 1'b0;
    check({14'h0, udpd_active, standby}, 16'h0001);
    fm(16'h79a5, 16, 1'b0); // resent once idle, with a trailing byte
    repeat (ENT_N) @(posedge core_clk);
    check({14'h0, udpd_active, standby}, 16'h0002);
    s = strobes;
    fmrp_host_model_i.frame(16'h0000, 8, 1'b0);
    fm(16'h0500, 8, 1'b0); // select falls again before the exit time ends
    check(16'(strobes), 16'(s));
    check({14'h0, udpd_active, standby}, 16'h0001);
    fm(16'h0500, 8, 1'b0);
    check(16'(strobes), 16'(s + 1));
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge core_clk); // host waits before its first select
    t_power_on();
    t_quad();
    t_reset();
    t_udpd();
    stop_test();
  end
  // watchdog, about ten times the expected run
  initial
  begin
    #200000;
    errors++;
    stop_test();
  end
endmodule
